/* File: uart_lfsm_defines.vh */
// Register offsets, field positions, reset values and timing counts for the serial channel.
// Assumes a 32-bit AXI4-Lite slave with one register per aligned word.
`ifndef UART_LFSM_DEFINES_VH
`define UART_LFSM_DEFINES_VH
`define OFS_DATA   8'h00
`define OFS_IER    8'h04
`define OFS_FIFO   8'h08
`define OFS_LFC    8'h0C
`define OFS_MC     8'h10
`define OFS_LS     8'h14
`define OFS_MS     8'h18
`define LFC_STOP   2
`define LFC_PEN    3
`define LFC_EPS    4
`define LFC_STICK  5
`define LFC_BRK    6
`define LFC_DIVISOR_BANK_SELECT   7
`define MC_DTR     0
`define MC_RTS     1
`define MC_USER_OUTPUT_A    2
`define MC_USER_OUTPUT_B    3
`define MC_LOOP    4
`define MC_AFE     5
`define LFC_RST    8'h00
`define MC_RST     8'h00
`define IER_RST    4'h0
`define DIV_RST    16'h0001
`define BIT_TICKS  6'h10
`define STOP15_TKS 6'h18
`define STOP2_TKS  6'h20
`define MID_TICK   4'h7
`define LAST_TICK  4'hF
`define MARK_SMPL  2'h2
`define RESP_OKAY  2'b00
`define RESP_SLV   2'b10
`endif

/* File: uart_line_format_status_modem_ctrl.v */
// One asynchronous serial channel with line format, line status and modem control.
// Assumes an AXI4-Lite master, synchronous line inputs and active-low modem pins.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "uart_lfsm_defines.vh"
module uart_line_format_status_modem_ctrl #(
  parameter DEPTH = 16
) (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire        txd,
  input  wire        rxd,
  input  wire        cts_n,
  input  wire        dsr_n,
  input  wire        ri_n,
  input  wire        dcd_n,
  output wire        dtr_n,
  output wire        rts_n,
  output wire        user_output_a_n,
  output wire        user_output_b_n,
  output wire        irq_o,
  output wire        irq_oe,
  output wire        aux_output_pin
);
  localparam PW = $clog2(DEPTH);
  localparam [PW:0] FULL_N = DEPTH[PW:0];
  localparam [2:0] S_IDLE = 3'd0, S_START = 3'd1, S_DATA = 3'd2, S_PAR = 3'd3,
                   S_STOP = 3'd4, S_BRK = 3'd5;

  reg  [7:0]  line_format_control;
  reg  [7:0]  modem_control;
  reg  [3:0]  irq_enable_reg;
  reg  [15:0] divisor;
  reg         fifo_enable_bit;
  reg  [15:0] baud_cnt;
  reg         aw_ok, w_ok;
  reg  [7:0]  aw_addr;
  reg  [7:0]  w_data;
  reg         w_lane0;
  wire        divisor_bank_select = line_format_control[`LFC_DIVISOR_BANK_SELECT];
  wire        loop = modem_control[`MC_LOOP];
  wire        afe  = modem_control[`MC_AFE];

  // Bus handshakes: one write and one read in flight
  assign s_axi_awready = !aw_ok && !s_axi_bvalid;
  assign s_axi_wready  = !w_ok && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  wire do_wr = aw_ok && w_ok && !s_axi_bvalid;
  wire do_rd = s_axi_arvalid && s_axi_arready;
  wire wr_en = do_wr && w_lane0;
  wire wr_dat = wr_en && aw_addr == `OFS_DATA && !divisor_bank_select;
  wire wr_dll = wr_en && aw_addr == `OFS_DATA && divisor_bank_select;
  wire wr_dlm = wr_en && aw_addr == `OFS_IER && divisor_bank_select;
  wire wr_fcr = wr_en && aw_addr == `OFS_FIFO;
  wire rd_dat = do_rd && s_axi_araddr == `OFS_DATA && !divisor_bank_select;
  wire rd_ls  = do_rd && s_axi_araddr == `OFS_LS;
  wire rd_ms  = do_rd && s_axi_araddr == `OFS_MS;
  wire fifo_chg = wr_fcr && w_data[0] != fifo_enable_bit;
  wire rx_clr = wr_fcr && (w_data[1] || fifo_chg);
  wire tx_clr = wr_fcr && (w_data[2] || fifo_chg);

  // Write address and data latch independently, then commit together
  always @(posedge clk) begin
    if (rst) begin
      aw_ok <= 1'b0;
      w_ok <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok <= 1'b1;
        w_data <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        aw_ok <= 1'b0;
        w_ok <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `OFS_MC) ? `RESP_SLV : `RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control registers; status register is read only and ignores writes
  always @(posedge clk) begin
    if (rst) begin
      line_format_control <= `LFC_RST;
      modem_control <= `MC_RST;
      irq_enable_reg <= `IER_RST;
      divisor <= `DIV_RST;
      fifo_enable_bit <= 1'b0;
    end else begin
      if (wr_en && aw_addr == `OFS_LFC) line_format_control <= w_data;
      if (wr_en && aw_addr == `OFS_MC) modem_control <= {2'b00, w_data[5:0]};
      if (wr_en && aw_addr == `OFS_IER && !divisor_bank_select) irq_enable_reg <= w_data[3:0];
      if (wr_dll) divisor[7:0] <= w_data;
      if (wr_dlm) divisor[15:8] <= w_data;
      if (wr_fcr) fifo_enable_bit <= w_data[0];
    end
  end

  // 16x tick; reloaded on divisor write so a new rate starts cleanly
  wire [15:0] div_m1 = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
  wire tick = baud_cnt >= div_m1;
  always @(posedge clk) begin
    if (rst || wr_dll || wr_dlm || tick) baud_cnt <= 16'h0000;
    else baud_cnt <= baud_cnt + 16'h0001;
  end

  // Character format shared by both directions
  wire [2:0] last_bit = {1'b0, line_format_control[1:0]} + 3'd4;
  wire pen   = line_format_control[`LFC_PEN];
  wire eps   = line_format_control[`LFC_EPS];
  wire stick = line_format_control[`LFC_STICK];
  wire [7:0] len_mask = 8'hFF >> (3'd7 - last_bit);
  function par_of;
    input [7:0] d;
    input e, s;
    begin
      par_of = s ? ~e : (e ? ^d : ~^d);
    end
  endfunction

  // Transmit buffer: capacity DEPTH in FIFO mode, one holding slot otherwise
  reg [7:0]  tx_mem [0:DEPTH-1];
  reg [PW-1:0] tx_wp, tx_rp;
  reg [PW:0] tx_cnt;
  wire [PW:0] tx_cap = fifo_enable_bit ? FULL_N : {{PW{1'b0}}, 1'b1};
  wire tx_full = tx_cnt == tx_cap;
  wire tx_holding_empty_flag = tx_cnt == {(PW+1){1'b0}};
  reg  [2:0] tx_st;
  reg  [5:0] tx_tk;
  reg  [2:0] tx_bit;
  reg  [7:0] tx_shift;
  reg        tx_par, tx_line;
  wire cts_int = loop ? modem_control[`MC_RTS] : ~cts_n;
  wire tx_go = !tx_holding_empty_flag && (!afe || cts_int);
  wire tx_push = wr_dat && !tx_full;
  wire tx_pop = tx_st == S_IDLE && tx_go && !tx_clr;
  wire [5:0] stop_tks = !line_format_control[`LFC_STOP] ? `BIT_TICKS :
                        (line_format_control[1:0] == 2'b00) ? `STOP15_TKS : `STOP2_TKS;
  wire tx_bit_end = tick && tx_tk == `BIT_TICKS - 6'h01;

  // Holding store pointers
  always @(posedge clk) begin
    if (rst || tx_clr) begin
      tx_wp <= {PW{1'b0}};
      tx_rp <= {PW{1'b0}};
      tx_cnt <= {(PW+1){1'b0}};
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp] <= w_data;
        tx_wp <= tx_wp + 1'b1;
      end
      if (tx_pop) tx_rp <= tx_rp + 1'b1;
      if (tx_push && !tx_pop) tx_cnt <= tx_cnt + 1'b1;
      else if (tx_pop && !tx_push) tx_cnt <= tx_cnt - 1'b1;
    end
  end

  // Transmit shifter: start, data, optional parity, stop
  always @(posedge clk) begin
    if (rst) begin
      tx_st <= S_IDLE;
      tx_tk <= 6'h00;
      tx_bit <= 3'd0;
      tx_shift <= 8'h00;
      tx_par <= 1'b0;
      tx_line <= 1'b1;
    end else begin
      case (tx_st)
        S_IDLE: begin
          tx_line <= 1'b1;
          tx_tk <= 6'h00;
          if (tx_pop) begin
            tx_shift <= tx_mem[tx_rp] & len_mask;
            tx_par <= par_of(tx_mem[tx_rp] & len_mask, eps, stick);
            tx_line <= 1'b0;
            tx_st <= S_START;
          end
        end
        S_START, S_DATA, S_PAR: begin
          if (tick) tx_tk <= tx_tk + 6'h01;
          if (tx_bit_end) begin
            tx_tk <= 6'h00;
            if (tx_st == S_START) begin
              tx_st <= S_DATA;
              tx_bit <= 3'd0;
              tx_line <= tx_shift[0];
            end else if (tx_st == S_DATA && tx_bit != last_bit) begin
              tx_bit <= tx_bit + 3'd1;
              tx_line <= tx_shift[tx_bit + 3'd1];
            end else if (tx_st == S_DATA && pen) begin
              tx_st <= S_PAR;
              tx_line <= tx_par;
            end else begin
              tx_st <= S_STOP;
              tx_line <= 1'b1;
            end
          end
        end
        S_STOP: begin
          if (tick) tx_tk <= tx_tk + 6'h01;
          if (tick && tx_tk == stop_tks - 6'h01) tx_st <= S_IDLE;
        end
        default: tx_st <= S_IDLE;
      endcase
    end
  end

  wire tx_all_empty_flag = tx_holding_empty_flag && tx_st == S_IDLE;
  // Break and loopback act on the pin only; loopback sees the raw shifter
  assign txd = loop ? 1'b1 : (line_format_control[`LFC_BRK] ? 1'b0 : tx_line);
  wire rx_in = loop ? tx_line : rxd;

  // Receive store keeps {break, framing, parity, data} per character
  reg  [10:0] rx_mem [0:DEPTH-1];
  reg  [PW-1:0] rx_wp, rx_rp;
  reg  [PW:0] rx_cnt;
  reg  [PW:0] err_cnt;
  reg  [2:0]  rx_st;
  reg  [3:0]  rx_tk;
  reg  [2:0]  rx_bit;
  reg  [7:0]  rx_data;
  reg         rx_pbad;
  reg  [1:0]  mark_cnt;
  reg         rx_done;
  reg  [10:0] rx_word;
  wire [PW:0] rx_cap = fifo_enable_bit ? FULL_N : {{PW{1'b0}}, 1'b1};
  wire rx_full = rx_cnt == rx_cap;
  wire rx_char_ready = rx_cnt != {(PW+1){1'b0}};
  // Non-FIFO overwrite is a push plus pop; FIFO mode drops the new character
  wire rx_push = rx_done && (!rx_full || !fifo_enable_bit);
  wire rx_pop = (rd_dat && rx_char_ready) || (rx_done && rx_full && !fifo_enable_bit);
  wire ovr_evt = rx_done && rx_full;
  wire rx_mid = tick && rx_tk == `LAST_TICK;
  wire push_err = |rx_word[10:8];
  wire pop_err = |rx_mem[rx_rp][10:8];

  // Receive shifter with false-start rejection
  always @(posedge clk) begin
    if (rst) begin
      rx_st <= S_IDLE;
      rx_tk <= 4'h0;
      rx_bit <= 3'd0;
      rx_data <= 8'h00;
      rx_pbad <= 1'b0;
      mark_cnt <= 2'd0;
      rx_done <= 1'b0;
      rx_word <= 11'h000;
    end else begin
      rx_done <= 1'b0;
      if (tick) rx_tk <= rx_tk + 4'h1;
      case (rx_st)
        S_IDLE: begin
          rx_tk <= 4'h0;
          if (tick && !rx_in) rx_st <= S_START;
        end
        S_START: begin
          if (tick && rx_tk == `MID_TICK) begin
            rx_tk <= 4'h0;
            rx_bit <= 3'd0;
            rx_data <= 8'h00;
            rx_st <= rx_in ? S_IDLE : S_DATA;
          end
        end
        S_DATA: begin
          if (rx_mid) begin
            rx_data[rx_bit] <= rx_in;
            rx_bit <= rx_bit + 3'd1;
            if (rx_bit == last_bit) rx_st <= pen ? S_PAR : S_STOP;
          end
        end
        S_PAR: begin
          if (rx_mid) begin
            rx_pbad <= rx_in != par_of(rx_data, eps, stick);
            rx_st <= S_STOP;
          end
        end
        S_STOP: begin
          // Only the first stop bit is looked at
          if (rx_mid) begin
            rx_done <= 1'b1;
            mark_cnt <= 2'd0;
            if (!rx_in && rx_data == 8'h00 && (!pen || !rx_pbad || !stick)) begin
              rx_word <= {1'b1, 1'b1, 1'b0, 8'h00};
              rx_st <= S_BRK;
            end else if (!rx_in) begin
              rx_word <= {1'b0, 1'b1, pen && rx_pbad, rx_data};
              rx_bit <= 3'd0;
              rx_data <= 8'h00;
              rx_st <= S_DATA;
            end else begin
              rx_word <= {1'b0, 1'b0, pen && rx_pbad, rx_data};
              rx_st <= S_IDLE;
            end
            rx_pbad <= 1'b0;
          end
        end
        S_BRK: begin
          // A break holds the receiver until the line marks twice
          if (tick) mark_cnt <= rx_in ? mark_cnt + 2'd1 : 2'd0;
          if (tick && rx_in && mark_cnt == `MARK_SMPL - 2'd1) rx_st <= S_IDLE;
        end
        default: rx_st <= S_IDLE;
      endcase
    end
  end

  // Receive store pointers and count of characters carrying errors
  always @(posedge clk) begin
    if (rst || rx_clr) begin
      rx_wp <= {PW{1'b0}};
      rx_rp <= {PW{1'b0}};
      rx_cnt <= {(PW+1){1'b0}};
      err_cnt <= {(PW+1){1'b0}};
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp] <= rx_word;
        rx_wp <= rx_wp + 1'b1;
      end
      if (rx_pop) rx_rp <= rx_rp + 1'b1;
      if (rx_push && !rx_pop) rx_cnt <= rx_cnt + 1'b1;
      else if (rx_pop && !rx_push) rx_cnt <= rx_cnt - 1'b1;
      err_cnt <= err_cnt + {{PW{1'b0}}, rx_push && push_err}
                         - {{PW{1'b0}}, rx_pop && pop_err};
    end
  end

  // Errors surface one cycle after a character becomes the head
  reg  head_new;
  reg  oe_flag, rx_parity_err_flag, rx_framing_err_flag, rx_break_flag;
  wire [2:0] head_err = (head_new && rx_char_ready) ? rx_mem[rx_rp][10:8] : 3'b000;
  always @(posedge clk) begin
    if (rst) begin
      head_new <= 1'b0;
      oe_flag <= 1'b0;
      rx_parity_err_flag <= 1'b0;
      rx_framing_err_flag <= 1'b0;
      rx_break_flag <= 1'b0;
    end else begin
      head_new <= (rx_push && !rx_char_ready) || (rx_pop && rx_cnt > 1) || (rx_push && rx_pop);
      // A new error in the read cycle survives the clear
      oe_flag <= (oe_flag && !rd_ls) || ovr_evt;
      rx_parity_err_flag <= (rx_parity_err_flag && !rd_ls) || head_err[0];
      rx_framing_err_flag <= (rx_framing_err_flag && !rd_ls) || head_err[1];
      rx_break_flag <= (rx_break_flag && !rd_ls) || head_err[2];
    end
  end
  wire fifo_error_summary = fifo_enable_bit && err_cnt != {(PW+1){1'b0}};
  wire [7:0] line_status = {fifo_error_summary, tx_all_empty_flag, tx_holding_empty_flag,
                            rx_break_flag, rx_framing_err_flag, rx_parity_err_flag,
                            oe_flag, rx_char_ready};

  // Modem inputs: loopback takes them from the control bits
  wire [3:0] mdm_now = loop ? {modem_control[`MC_USER_OUTPUT_B], modem_control[`MC_USER_OUTPUT_A],
                               modem_control[`MC_DTR], modem_control[`MC_RTS]}
                            : {~dcd_n, ~ri_n, ~dsr_n, ~cts_n};
  reg  [3:0] mdm_prev, mdm_delta;
  wire [3:0] mdm_evt = {mdm_now[3] ^ mdm_prev[3], mdm_prev[2] & ~mdm_now[2],
                        mdm_now[1] ^ mdm_prev[1], (mdm_now[0] ^ mdm_prev[0]) & ~afe};
  always @(posedge clk) begin
    if (rst) begin
      mdm_prev <= 4'h0;
      mdm_delta <= 4'h0;
    end else begin
      mdm_prev <= mdm_now;
      mdm_delta <= (mdm_delta & ~{4{rd_ms}}) | mdm_evt;
    end
  end

  // Read data path; side effects happen when the address is taken
  always @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (do_rd) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case (s_axi_araddr[7:2])
        6'd0: s_axi_rdata <= {24'h00_0000, divisor_bank_select ? divisor[7:0] : rx_mem[rx_rp][7:0]};
        6'd1: s_axi_rdata <= {24'h00_0000, divisor_bank_select ? divisor[15:8] : {4'h0, irq_enable_reg}};
        6'd2: s_axi_rdata <= {24'h00_0000, 7'h00, fifo_enable_bit};
        6'd3: s_axi_rdata <= {24'h00_0000, line_format_control};
        6'd4: s_axi_rdata <= {24'h00_0000, modem_control};
        6'd5: s_axi_rdata <= {24'h00_0000, line_status};
        6'd6: s_axi_rdata <= {24'h00_0000, mdm_now, mdm_delta};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `RESP_SLV;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Interrupt sources, each gated by its enable, also during loopback
  assign irq_o = (irq_enable_reg[0] && rx_char_ready) ||
                 (irq_enable_reg[1] && tx_holding_empty_flag) ||
                 (irq_enable_reg[2] && |line_status[4:1]) ||
                 (irq_enable_reg[3] && |mdm_delta);
  assign irq_oe = modem_control[`MC_USER_OUTPUT_B];
  assign aux_output_pin = ~modem_control[`MC_USER_OUTPUT_B];

  // Auto request-to-send drops while the receive store is full
  wire rts_auto = afe && modem_control[`MC_RTS];
  assign dtr_n = loop | ~modem_control[`MC_DTR];
  assign rts_n = loop | ~modem_control[`MC_RTS] | (rts_auto & rx_full);
  assign user_output_a_n = loop | ~modem_control[`MC_USER_OUTPUT_A];
  assign user_output_b_n = loop | ~modem_control[`MC_USER_OUTPUT_B];
endmodule // uart_line_format_status_modem_ctrl

/* File: uart_remote_peer.sv */
// Remote serial device model: drives the receive line, decodes the transmit line.
// Assumes divisor 1, so one bit lasts 16 clock cycles; the line idles high.
`timescale 1ns/1ps
module uart_remote_peer (
  input  wire logic clk,
  input  wire logic txd,
  output logic      rxd
);
  localparam int BITC = 16;
  initial rxd = 1'b1;
  // Frame goes out lsb first, then the line is released to the mark level
  task automatic send(input logic [15:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (BITC) @(posedge clk);
    end
    rxd <= 1'b1;
    // One mark cycle so a following frame never drives the line in the same step
    @(posedge clk);
  endtask
  // Bounded wait for a start edge; bits sampled mid-cell so no stop bit is missed
  task automatic recv(output logic [15:0] f, output time t0, input int n);
    f = '0;
    for (int w = 0; w < 4000 && txd; w++) @(posedge clk);
    t0 = $time;
    repeat (BITC / 2) @(posedge clk);
    for (int i = 0; i < n; i++) begin
      if (i > 0) repeat (BITC) @(posedge clk);
      f[i] = txd;
    end
  endtask
endmodule // uart_remote_peer

/* File: uart_lfsm_monitor.sv */
// Port checker for the serial channel: bus handshakes and modem pin relations.
// Assumes it is bound to the channel top and sees only its ports.
`timescale 1ns/1ps
`include "uart_lfsm_defines.vh"
module uart_lfsm_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        txd,
  input wire logic        dtr_n,
  input wire logic        rts_n,
  input wire logic        user_output_b_n,
  input wire logic        irq_oe
,
  input wire logic        aux_output_pin
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Modem pins, interrupt gate and idle levels
  aux_invert_a: assert property (aux_output_pin == !irq_oe)
    else $error("aux pin does not mirror interrupt gate");
  user_b_gate_a: assert property (!user_output_b_n |-> irq_oe)
    else $error("user output b active without interrupt gate");
  reset_idle_a: assert property ($fell(rst) |-> txd && dtr_n && rts_n && !irq_oe)
    else $error("outputs not idle after reset");
  // Bus handshakes: answers at the stated cycle and held until taken
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer not at cycle two");
  write_block_a: assert property (s_axi_bvalid |-> !(s_axi_awready || s_axi_wready))
    else $error("write taken while answer pending");
  write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  // Addresses 0x19 to 0x1B still decode to the modem status word
  unmapped_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h1C
    |=> s_axi_rresp == `RESP_SLV && s_axi_rdata == 32'h0) else $error("unmapped read answer");
  cover property (s_axi_bvalid);
  cover property ($fell(txd));
  cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLV);
endmodule // uart_lfsm_monitor
bind uart_line_format_status_modem_ctrl uart_lfsm_monitor mon (.*);

/* File: uart_line_format_status_modem_ctrl_tb_top.sv */
// Self-checking bench for the serial channel: register tasks and frame checks.
// Assumes divisor 1 and the remote peer model on the serial lines.
`timescale 1ns/1ps
`include "uart_lfsm_defines.vh"
module uart_line_format_status_modem_ctrl_tb_top;
  logic clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txd, rxd;
  logic cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, user_output_a_n, user_output_b_n;
  logic irq_o, irq_oe, aux_output_pin;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, v;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [15:0] f1, f2;
  logic [7:0]  lcs [6] = '{8'h04, 8'h05, 8'h0F, 8'h1A, 8'h29, 8'h3B};
  time         t1, t2;
  int          error_cnt = 0, samples_checked = 0, n;
  uart_line_format_status_modem_ctrl DUT (.*);
  uart_remote_peer peer (.clk(clk), .txd(txd), .rxd(rxd));
  // Free-running clock, 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic report_and_stop;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo;
    error_cnt++;
    report_and_stop();
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    resp = s_axi_bresp;
    if (k == 99) tmo();
    @(posedge clk);
  endtask
  // Read: the extra edge at the end keeps ready from being set twice in one step
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int k;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (k = 0; k < 99; k++) begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    s_axi_rready <= 1'b0;
    d = s_axi_rdata[7:0];
    resp = s_axi_rresp;
    if (k == 99) tmo();
    @(posedge clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    rd(a, v);
    chk(v, e);
  endtask
  // Expected frame, lsb first: start, data, optional parity, stop level
  function automatic logic [15:0] frm(input logic [7:0] lc, input logic [7:0] d);
    logic [15:0] f;
    int nd;
    nd = 5 + lc[1:0];
    f = 16'hFFFE;
    for (int i = 0; i < nd; i++) f[i + 1] = d[i];
    if (lc[3]) f[nd + 1] = lc[5] ? !lc[4] : (^(d & (8'hFF >> (8 - nd)))) ^ !lc[4];
    return f & ~(16'hFFFF << (nd + 2 + lc[3]));
  endfunction
  // Receive one frame, then the status and the character it left behind
  task automatic rx(input logic [15:0] f, input logic [7:0] ls, input logic [7:0] d);
    peer.send(f, 11);
    repeat (4) @(posedge clk);
    rc(`OFS_LS, ls);
    rc(`OFS_DATA, d);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    {cts_n, dsr_n, ri_n, dcd_n} = 4'h0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rc(`OFS_LFC, 8'h00);
    rc(`OFS_LS, 8'h60);
    wr(`OFS_LS, 8'hFF);
    rc(`OFS_LS, 8'h60);
    rc(8'h1C, 8'h00);
    chk(resp, `RESP_SLV);
    wr(`OFS_IER, 8'h0F);
    chk(irq_o, 1'b1);
    wr(`OFS_LFC, 8'h83);
    wr(`OFS_DATA, 8'h07);
    rc(`OFS_DATA, 8'h07);
    rc(`OFS_IER, 8'h00);
    wr(`OFS_DATA, 8'h01);
    wr(`OFS_LFC, 8'h43);
    chk(txd, 1'b0);
    wr(`OFS_LFC, 8'h03);
    chk(txd, 1'b1);
    rc(`OFS_IER, 8'h0F);
    wr(`OFS_IER, 8'h00);
    chk(irq_o, 1'b0);
    for (int m = 0; m < 16; m++) begin
      wr(`OFS_MC, m[7:0]);
      chk({dtr_n, rts_n, user_output_a_n, user_output_b_n, irq_oe, aux_output_pin},
          {~m[0], ~m[1], ~m[2], ~m[3], m[3], ~m[3]});
    end
    wr(`OFS_MC, 8'h1B);
    chk({dtr_n, rts_n, user_output_a_n, user_output_b_n}, 4'hF);
    rd(`OFS_MS, v);
    chk(v[7:4], 4'hB);
    wr(`OFS_DATA, 8'hC3);
    repeat (200) @(posedge clk);
    chk(txd, 1'b1);
    rc(`OFS_DATA, 8'hC3);
    wr(`OFS_MC, 8'h00);
    foreach (lcs[j]) begin
      wr(`OFS_LFC, lcs[j]);
      n = 7 + lcs[j][1:0] + lcs[j][3];
      fork
        begin
          wr(`OFS_DATA, 8'hA5);
          wr(`OFS_DATA, 8'h5A);
          rc(`OFS_LS, 8'h00);
        end
        begin
          peer.recv(f1, t1, n);
          peer.recv(f2, t2, n);
        end
      join
      chk(f1, frm(lcs[j], 8'hA5));
      chk(f2, frm(lcs[j], 8'h5A));
      // The shifter spends one idle cycle reloading between characters
      chk(16'((t2 - t1) / 10),
          16'(16 * (n - 1) + (lcs[j][2] ? (lcs[j][1:0] == 0 ? 24 : 32) : 16) + 1));
      repeat (40) @(posedge clk);
      rc(`OFS_LS, 8'h60);
    end
    wr(`OFS_LFC, 8'h1B);
    rx(16'h0478, 8'h61, 8'h3C);
    rc(`OFS_LS, 8'h60);
    rx(16'h0678, 8'h65, 8'h3C);
    rc(`OFS_LS, 8'h60);
    rx(16'h0078, 8'h69, 8'h3C);
    repeat (300) @(posedge clk);
    rc(`OFS_DATA, 8'hFF);
    rd(`OFS_LS, v);
    peer.send(16'h0000, 16);
    repeat (4) @(posedge clk);
    rc(`OFS_LS, 8'h79);
    rc(`OFS_DATA, 8'h00);
    peer.send(16'h0478, 11);
    rx(16'h04B4, 8'h63, 8'h5A);
    wr(`OFS_FIFO, 8'h01);
    peer.send(16'h0678, 11);
    peer.send(16'h04B4, 11);
    repeat (4) @(posedge clk);
    rc(`OFS_LS, 8'hE5);
    rc(`OFS_DATA, 8'h3C);
    rc(`OFS_LS, 8'h61);
    rc(`OFS_DATA, 8'h5A);
    wr(`OFS_FIFO, 8'h00);
    wr(`OFS_LFC, 8'h03);
    cts_n <= 1'b1;
    wr(`OFS_MC, 8'h20);
    wr(`OFS_DATA, 8'h96);
    repeat (50) @(posedge clk);
    chk(txd, 1'b1);
    fork
      peer.recv(f1, t1, 10);
      cts_n <= 1'b0;
    join
    chk(f1, frm(8'h03, 8'h96));
    report_and_stop();
  end
endmodule // uart_line_format_status_modem_ctrl_tb_top
